// ### core/bobde_pkg.sv
// constants, carriers and state for the byte-op / branch decode-execute core
// assumes a 14-bit instruction word and an 8-bit file register bus
package bobde_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int PAGE_W = 5;

  // instruction field positions
  localparam int PFX_HI = 13;
  localparam int PFX_LO = 12;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int DEST_POS = 7;
  localparam int FADDR_HI = 6;
  localparam int BR_HI = 13;
  localparam int BR_LO = 11;
  localparam int IMM_HI = 10;
  localparam int LIT_HI = 7;
  localparam int ORL_HI = 13;
  localparam int ORL_LO = 8;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;

  // encodings
  localparam logic [1:0] PFX_FILE = 2'h0;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [2:0] BRANCH_CODE = 3'h5;
  localparam logic [5:0] ORLIT_CODE = 6'h38;
  localparam logic DEST_ACC = 1'b0;

  // arithmetic operands and reset values
  localparam logic [7:0] INC_ADDEND = 8'h01;
  localparam logic [7:0] DEC_ADDEND = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [6:0] FADDR_RST = 7'h00;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } bobde_flags_t;

  typedef struct packed {
    logic we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bobde_fwrite_t;

  typedef enum logic {ST_EXEC, ST_DISCARD} bobde_phase_t;

  typedef struct packed {
    bobde_phase_t st;
    logic [DATA_W-1:0] acc;
    bobde_flags_t flags;
    bobde_fwrite_t fwr;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
  } bobde_state_t;

  localparam bobde_flags_t FLAGS_RST = '{c: 1'b0, dc: 1'b0, z: 1'b0};

endpackage

// ### core/bobde_addsub.sv
// 8-bit adder with carry out and nibble carry for increment and decrement
// assumes operands are stable within the cycle; purely combinational
`timescale 1ns/1ns
`default_nettype none
module bobde_addsub #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a, // file operand
  input wire logic [WIDTH-1:0] b, // addend, plus one or minus one
  output logic [WIDTH-1:0] sum, // result byte
  output logic carry, // carry out, no borrow on decrement
  output logic nib_carry // carry out of low nibble
);
  logic [WIDTH:0] full;
  logic [4:0] low;

  always_comb begin
    full = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    sum = full[WIDTH-1:0];
    carry = full[WIDTH];
    nib_carry = low[4];
  end
endmodule
`default_nettype wire

// ### core/bobde_core.sv
// decode and execute of file byte ops, skip ops, or ops and the branch
// assumes file_rdata answers file_addr in the same cycle; other opcodes run as no-op
`timescale 1ns/1ns
`default_nettype none
module bobde_core (
  input wire logic clk_sys, // core clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic instr_valid, // fetched word present
  input wire logic [bobde_pkg::INSTR_W-1:0] instr_word, // fetched word
  output logic instr_ready, // word taken when valid
  input wire logic [bobde_pkg::PAGE_W-1:0] program_page_latch, // page latch bits
  output logic [bobde_pkg::FADDR_W-1:0] file_addr, // file read address
  input wire logic [bobde_pkg::DATA_W-1:0] file_rdata, // file read data
  output bobde_pkg::bobde_fwrite_t file_wr, // file write, one-cycle strobe
  output logic [bobde_pkg::DATA_W-1:0] acc, // working accumulator
  output bobde_pkg::bobde_flags_t flags, // carry, digit carry, zero
  output logic pc_load, // one-cycle program counter load
  output logic [bobde_pkg::PC_W-1:0] pc_value, // program counter load value
  output logic second_cycle // current word is discarded as no-op
);
  import bobde_pkg::*;

  bobde_state_t q;
  bobde_state_t next_q;

  logic take;
  logic exec_take;
  logic [1:0] pfx;
  logic [3:0] op;
  logic dest;
  logic is_file;
  logic is_branch;
  logic is_orlit;
  logic [DATA_W-1:0] addend;
  logic [DATA_W-1:0] sum;
  logic carry;
  logic nib_carry;
  logic [DATA_W-1:0] res;
  logic handled;
  logic upd_z;
  logic upd_cdc;
  logic skip_op;

  assign instr_ready = 1'b1;
  assign take = instr_valid && instr_ready;
  assign exec_take = take && (q.st == ST_EXEC);
  assign pfx = instr_word[PFX_HI:PFX_LO];
  assign op = instr_word[OP_HI:OP_LO];
  assign dest = instr_word[DEST_POS];
  assign is_file = (pfx == PFX_FILE);
  assign is_branch = (instr_word[BR_HI:BR_LO] == BRANCH_CODE);
  assign is_orlit = (instr_word[ORL_HI:ORL_LO] == ORLIT_CODE);
  assign file_addr = instr_word[FADDR_HI:0];
  assign addend = ((op == OP_DEC) || (op == OP_DECSZ)) ? DEC_ADDEND : INC_ADDEND;

  bobde_addsub #(
    .WIDTH(DATA_W)
  ) bobde_addsub_inst (
    .a(file_rdata),
    .b(addend),
    .sum(sum),
    .carry(carry),
    .nib_carry(nib_carry)
  );

  // result and flag selection for file-prefix operations
  always_comb begin
    res = ZERO_BYTE;
    handled = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    skip_op = 1'b0;
    if (is_file) begin
      case (op)
        OP_COM: begin
          res = ~file_rdata;
          handled = 1'b1;
          upd_z = 1'b1;
        end
        OP_DEC, OP_INC: begin
          res = sum;
          handled = 1'b1;
          upd_z = 1'b1;
          upd_cdc = 1'b1;
        end
        OP_DECSZ, OP_INCSZ: begin
          res = sum;
          handled = 1'b1;
          skip_op = 1'b1;
        end
        OP_IOR: begin
          res = acc | file_rdata;
          handled = 1'b1;
          upd_z = 1'b1;
        end
        default: begin
          handled = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    next_q = q;
    next_q.pc_load = 1'b0;
    next_q.fwr.we = 1'b0;
    if (take) begin
      case (q.st)
        ST_DISCARD: begin
          // prefetched word dropped, runs as a no-op
          next_q.st = ST_EXEC;
        end
        ST_EXEC: begin
          if (handled) begin
            if (dest == DEST_ACC) begin
              next_q.acc = res;
            end else begin
              next_q.fwr.we = 1'b1;
              next_q.fwr.addr = file_addr;
              next_q.fwr.data = res;
            end
            if (upd_z) begin
              next_q.flags.z = (res == ZERO_BYTE);
            end
            if (upd_cdc) begin
              next_q.flags.c = carry;
              next_q.flags.dc = nib_carry;
            end
            if (skip_op && (res == ZERO_BYTE)) begin
              next_q.st = ST_DISCARD;
            end
          end else if (is_branch) begin
            next_q.pc_load = 1'b1;
            next_q.pc_value = {program_page_latch[PAGE_HI:PAGE_LO],
                               instr_word[IMM_HI:0]};
            next_q.st = ST_DISCARD;
          end else if (is_orlit) begin
            next_q.acc = acc | instr_word[LIT_HI:0];
            next_q.flags.z = ((acc | instr_word[LIT_HI:0]) == ZERO_BYTE);
          end
        end
        default: begin
          next_q.st = ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q.st <= ST_EXEC;
      q.acc <= ACC_RST;
      q.flags <= FLAGS_RST;
      q.fwr.we <= 1'b0;
      q.fwr.addr <= FADDR_RST;
      q.fwr.data <= ZERO_BYTE;
      q.pc_load <= 1'b0;
      q.pc_value <= PC_RST;
    end else begin
      q <= next_q;
    end
  end

  assign file_wr = q.fwr;
  assign acc = q.acc;
  assign flags = q.flags;
  assign pc_load = q.pc_load;
  assign pc_value = q.pc_value;
  assign second_cycle = (q.st == ST_DISCARD);

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  AST_DEST_FILE: assert property (
    exec_take && is_file && (op == OP_IOR) && dest
    |=> file_wr.we && (file_wr.addr == $past(file_addr))
        && (file_wr.data == ($past(acc) | $past(file_rdata))))
    else $error("or to file did not write the addressed register");

  AST_DEST_ACC: assert property (
    exec_take && is_file && handled && !dest
    |=> !file_wr.we && (acc == $past(res)))
    else $error("accumulator destination wrote the file or missed the result");

  AST_COMPLEMENT: assert property (
    exec_take && is_file && (op == OP_COM) && !dest
    |=> (acc == ~$past(file_rdata)) && (flags.c == $past(flags.c))
        && (flags.dc == $past(flags.dc)) && (flags.z == ($past(file_rdata) == 8'hFF))
        && !second_cycle)
    else $error("complement result or flags wrong");

  AST_DECREMENT: assert property (
    exec_take && is_file && (op == OP_DEC)
    |=> (flags.z == ($past(file_rdata) == 8'h01))
        && (flags.c == ($past(file_rdata) != 8'h00))
        && (flags.dc == ($past(file_rdata[3:0]) != 4'h0)) && !second_cycle)
    else $error("decrement flags wrong");

  AST_DECSKIP_FLAGS: assert property (
    exec_take && is_file && (op == OP_DECSZ)
    |=> (flags == $past(flags)))
    else $error("decrement-and-skip changed a flag");

  AST_SKIP_DISCARD: assert property (
    exec_take && is_file && (op == OP_DECSZ) && (file_rdata == 8'h01)
    |=> second_cycle)
    else $error("zero result did not discard the fetched word");

  // the dropped word must leave no trace at all
  AST_DISCARD_NOP: assert property (
    take && second_cycle
    |=> !second_cycle && !file_wr.we && !pc_load && (acc == $past(acc))
        && (flags == $past(flags)))
    else $error("discarded word changed state");

  // no word offered: the discard waits
  AST_DISCARD_WAIT: assert property (
    !instr_valid && second_cycle
    |=> second_cycle && !file_wr.we && !pc_load)
    else $error("discard state left without a word");

  AST_NO_SKIP: assert property (
    exec_take && is_file && (op == OP_INCSZ) && (file_rdata != 8'hFF)
    |=> !second_cycle)
    else $error("nonzero skip result took a second cycle");

  AST_BRANCH_PC: assert property (
    exec_take && is_branch
    |=> pc_load && (pc_value[10:0] == $past(instr_word[10:0]))
        && (pc_value[12:11] == $past(program_page_latch[4:3])))
    else $error("branch target wrong");

  AST_BRANCH_TWO: assert property (
    exec_take && is_branch
    |=> second_cycle && (flags == $past(flags)) && (acc == $past(acc)) ##1 !pc_load)
    else $error("branch did not take two cycles or changed flags");

  AST_INCSKIP: assert property (
    exec_take && is_file && (op == OP_INCSZ) && (file_rdata == 8'hFF)
    |=> (flags == $past(flags)) && second_cycle)
    else $error("increment-and-skip changed a flag or missed the skip");

  AST_OR_LITERAL: assert property (
    exec_take && is_orlit
    |=> (acc == ($past(acc) | $past(instr_word[7:0])))
        && (flags.z == (acc == 8'h00)) && !file_wr.we && !second_cycle)
    else $error("or literal result or zero flag wrong");

  AST_OR_FILE: assert property (
    exec_take && is_file && (op == OP_IOR) && !dest
    |=> (acc == ($past(acc) | $past(file_rdata))) && (flags.z == (acc == 8'h00))
        && (flags.c == $past(flags.c)))
    else $error("or with file result or zero flag wrong");

  AST_INCREMENT: assert property (
    exec_take && is_file && (op == OP_INC)
    |=> (flags.c == ($past(file_rdata) == 8'hFF))
        && (flags.dc == ($past(file_rdata[3:0]) == 4'hF))
        && (flags.z == ($past(file_rdata) == 8'hFF)) && !second_cycle)
    else $error("increment flags wrong");

  AST_COMPLEMENT_FILE: assert property (
    exec_take && is_file && (op == OP_COM) && dest
    |=> file_wr.we && (file_wr.data == ~$past(file_rdata)) && (acc == $past(acc)))
    else $error("complement to file wrong");

  AST_DEC_RESULT: assert property (
    exec_take && is_file && (op == OP_DEC)
    |=> (file_wr.we == $past(dest))
        && (($past(dest) ? file_wr.data : acc) == 8'($past(file_rdata) - 8'h01)))
    else $error("decrement result or destination wrong");

  AST_DECSKIP_RESULT: assert property (
    exec_take && is_file && (op == OP_DECSZ)
    |=> (file_wr.we == $past(dest))
        && (($past(dest) ? file_wr.data : acc) == 8'($past(file_rdata) - 8'h01)))
    else $error("decrement-and-skip result or destination wrong");

  AST_INCSKIP_RESULT: assert property (
    exec_take && is_file && (op == OP_INCSZ)
    |=> (file_wr.we == $past(dest))
        && (($past(dest) ? file_wr.data : acc) == 8'($past(file_rdata) + 8'h01)))
    else $error("increment-and-skip result or destination wrong");

  AST_INC_RESULT: assert property (
    exec_take && is_file && (op == OP_INC)
    |=> (file_wr.we == $past(dest))
        && (($past(dest) ? file_wr.data : acc) == 8'($past(file_rdata) + 8'h01)))
    else $error("increment result or destination wrong");

  // a load never repeats in the discarded cycle
  AST_PC_PULSE: assert property (
    pc_load |=> !pc_load)
    else $error("program counter load held two cycles");

endmodule
`default_nettype wire

// ### tb/bobde_core_bench.sv
// self-checking bench for the byte-op / branch decode-execute core
// assumes bobde_pkg; the bench models the file register array itself
`timescale 1ns/1ns
`default_nettype none
module bobde_core_bench;
  import bobde_pkg::*;
  logic clk_sys, arst_n, instr_valid, instr_ready, pc_load, second_cycle;
  logic [INSTR_W-1:0] instr_word;
  logic [PAGE_W-1:0] page;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0] file_rdata, acc, a, v, r;
  bobde_fwrite_t file_wr;
  bobde_flags_t flags, fsave;
  logic [PC_W-1:0] pc_value;
  logic [DATA_W-1:0] mem [128];
  int n_mismatch, check_count;

  bobde_core bobde_core_inst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_ready(instr_ready),
    .program_page_latch(page),
    .file_addr(file_addr),
    .file_rdata(file_rdata),
    .file_wr(file_wr),
    .acc(acc),
    .flags(flags),
    .pc_load(pc_load),
    .pc_value(pc_value),
    .second_cycle(second_cycle)
  );

  // file array answers in the same cycle
  assign file_rdata = mem[file_addr];
  always @(posedge clk_sys) begin
    if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic issue(input logic [13:0] w);
    instr_word = w;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic idle;
    instr_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [13:0] fop(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {PFX_FILE, op, d, f};
  endfunction

  function automatic logic [13:0] orl(input logic [7:0] k);
    return {ORLIT_CODE, k};
  endfunction

  task automatic t_or;
    issue(orl(8'h00));
    check(16'(flags.z), 16'h0001, "or lit zero");
    issue(orl(8'h3C));
    check(16'(acc), 16'h003C, "or lit acc");
    check(16'(flags.z), 16'h0000, "or lit nz");
    mem[2] = 8'hC0;
    issue(fop(OP_IOR, 1'b1, 7'h02));
    check(file_wr, {1'b1, 7'h02, 8'hFC}, "or file wr");
    check(16'(acc), 16'h003C, "or file acc kept");
    mem[2] = 8'h41;
    issue(fop(OP_IOR, 1'b0, 7'h02));
    check(16'(acc), 16'h007D, "or file acc");
    check(16'(file_wr.we), 16'h0000, "or file no wr");
    idle();
    $display("test or done");
  endtask

  task automatic t_com;
    mem[5] = 8'hA5;
    fsave = flags;
    issue(fop(OP_COM, 1'b0, 7'h05));
    check(16'(acc), 16'h005A, "com acc");
    check(16'(flags), 16'({fsave.c, fsave.dc, 1'b0}), "com flags");
    mem[6] = 8'hFF;
    issue(fop(OP_COM, 1'b1, 7'h06));
    check(file_wr, {1'b1, 7'h06, 8'h00}, "com wr");
    check(16'(flags.z), 16'h0001, "com z");
    check(16'(acc), 16'h005A, "com acc kept");
    idle();
    $display("test com done");
  endtask

  task automatic t_arith;
    logic [7:0] vals [4] = '{8'h00, 8'h0F, 8'h10, 8'hFF};
    foreach (vals[i]) begin
      v = vals[i];
      mem[9] = v;
      r = v - 8'h01;
      issue(fop(OP_DEC, 1'b0, 7'h09));
      check(16'(acc), 16'(r), "dec acc");
      check(16'(flags), 16'({v != 8'h00, v[3:0] != 4'h0, r == 8'h00}), "dec flags");
      mem[9] = v;
      r = v + 8'h01;
      issue(fop(OP_INC, 1'b1, 7'h09));
      check(file_wr, {1'b1, 7'h09, r}, "inc wr");
      check(16'(flags), 16'({v == 8'hFF, v[3:0] == 4'hF, r == 8'h00}), "inc flags");
    end
    idle();
    $display("test arith done");
  endtask

  task automatic t_skip;
    mem[3] = 8'h01;
    fsave = flags;
    a = acc;
    issue(fop(OP_DECSZ, 1'b1, 7'h03));
    check(file_wr, {1'b1, 7'h03, 8'h00}, "decsz wr");
    check(16'(second_cycle), 16'h0001, "decsz skip");
    check(16'(flags), 16'(fsave), "decsz flags");
    issue(orl(8'hFF));
    check(16'(acc), 16'(a), "skipped word acc");
    check(16'(second_cycle), 16'h0000, "skip ends");
    mem[4] = 8'hFF;
    issue(fop(OP_INCSZ, 1'b0, 7'h04));
    check(16'(acc), 16'h0000, "incsz acc");
    check(16'(flags), 16'(fsave), "incsz flags");
    idle();
    check(16'(second_cycle), 16'h0001, "incsz skip waits");
    issue(fop(OP_INCSZ, 1'b0, 7'h04));
    check(16'(acc), 16'h0000, "discarded incsz");
    check(16'(second_cycle), 16'h0000, "discarded incsz no skip");
    mem[4] = 8'h05;
    issue(fop(OP_DECSZ, 1'b0, 7'h04));
    check(16'(acc), 16'h0004, "decsz nz acc");
    check(16'(second_cycle), 16'h0000, "decsz no skip");
    mem[7] = 8'h7F;
    issue(fop(OP_INCSZ, 1'b1, 7'h07));
    check(file_wr, {1'b1, 7'h07, 8'h80}, "incsz nz wr");
    check(16'(second_cycle), 16'h0000, "incsz no skip");
    idle();
    $display("test skip done");
  endtask

  task automatic t_reset;
    mem[8] = 8'h01;
    issue(fop(OP_DECSZ, 1'b1, 7'h08));
    check(16'(second_cycle), 16'h0001, "pre reset skip");
    instr_valid = 1'b0;
    arst_n = 1'b0;
    @(posedge clk_sys);
    #1;
    check(16'({acc, flags, second_cycle}), 16'h0000, "reset mid skip");
    check(16'(file_wr), 16'h0000, "reset mid skip wr");
    @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    issue(orl(8'h21));
    check(16'(acc), 16'h0021, "first word after reset");
    check(16'(second_cycle), 16'h0000, "no skip after reset");
    idle();
    $display("test reset done");
  endtask

  task automatic t_branch;
    logic [4:0] pg [2] = '{5'h18, 5'h07};
    logic [10:0] k [2] = '{11'h555, 11'h2AA};
    foreach (pg[i]) begin
      page = pg[i];
      fsave = flags;
      a = acc;
      issue({BRANCH_CODE, k[i]});
      check(16'(pc_load), 16'h0001, "branch load");
      check(16'(pc_value), 16'({pg[i][4:3], k[i]}), "branch target");
      check(16'(second_cycle), 16'h0001, "branch two cycles");
      check(16'(flags), 16'(fsave), "branch flags");
      issue(orl(8'hFF));
      check(16'(pc_load), 16'h0000, "branch load pulse");
      check(16'(acc), 16'(a), "branch discard");
      check(16'(second_cycle), 16'h0000, "branch done");
      idle();
    end
    $display("test branch done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    page = 5'h00;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    check(16'(acc), 16'h0000, "reset acc");
    check(16'({flags, pc_load, second_cycle, instr_ready}), 16'h0001, "reset outs");
    t_or();
    t_com();
    t_arith();
    t_skip();
    t_branch();
    t_reset();
    arst_n = 1'b0;
    #1;
    check(16'(acc), 16'h0000, "mid reset acc");
    final_report();
  end
endmodule
`default_nettype wire
